// File: hdl/tmrwd_pkg.sv
/*
  tmrwd_pkg: constants, field positions, reset values and carrier types for
  the timer / watchdog / prescaler / interrupt block.
  assumes: one 200 MHz core clock; instruction cycle derived by an enable.
*/
package tmrwd_pkg;

  // ************************************************************
  // configuration register layout
  // ************************************************************
  localparam int          CFG_W          = 7;       // implemented bits
  localparam int          CFG_RATE_LSB   = 0;       // divide_ratio_field
  localparam int          CFG_OWNER_BIT  = 3;       // prescaler_owner_sel
  localparam int          CFG_EDGE_BIT   = 4;       // ext_clock_edge_sel
  localparam int          CFG_SRC_BIT    = 5;       // tick_source_sel
  localparam int          CFG_IRQA_BIT   = 6;       // ext_irq_a_edge_sel
  localparam logic [6:0]  CFG_RESET      = 7'h3f;   // all ones but irq edge

  // ************************************************************
  // interrupt register layout
  // ************************************************************
  localparam int          IRQ_OVF_BIT    = 0;
  localparam int          IRQ_A_BIT      = 2;
  localparam int          IRQ_B_BIT      = 3;
  localparam int          IRQ_MASTER_BIT = 7;
  localparam logic [7:0]  IRQ_FLAG_IMPL  = 8'h0d;   // implemented flag bits
  localparam logic [7:0]  IRQ_MASK_IMPL  = 8'h8d;   // implemented mask bits
  localparam logic [11:0] HW_VECTOR      = 12'h008;
  localparam logic [11:0] SW_VECTOR      = 12'h002;
  localparam int          PWR_WDT_EN_BIT = 7;       // watchdog_enable_bit
  localparam int          STAT_EXP_BIT   = 4;       // watchdog_expired_flag

  // ************************************************************
  // timing
  // ************************************************************
  localparam int          CLK_MHZ        = 200;
  localparam int          WDT_OSC_KHZ    = 128;     // nominal rc oscillator rate, plain default
  localparam int          WDT_TIMEOUT_MS = 18;
  localparam int          WDT_TIMEOUT_CYC = WDT_TIMEOUT_MS * WDT_OSC_KHZ; // in oscillator periods
  localparam int          INSTR_DIV      = 4;       // clocks per instruction
  localparam int          WRITE_HOLDOFF  = 2;       // instr cycles inhibited
  localparam logic [7:0]  PRESC_RESET    = 8'hff;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic       cfg_load;     // configuration-load instruction
    logic       cnt_write;    // instruction writes count_register
    logic       kick;         // watchdog_kick_instr
    logic       sleep;        // sleep instruction
    logic       ret;          // irq_return_instr
    logic       sw_irq;       // software interrupt instruction
    logic       mask_write;   // write of irq_mask_reg
    logic       flag_write;   // write of irq_flag_reg
    logic       pwr_write;    // write of power_ctrl_reg
    logic [7:0] wdata;        // work_register contents
  } tmrwd_cmd_t;

  typedef struct packed {
    logic [7:0] count;        // count_register
    logic [7:0] flag_read;    // flags and mask combined
    logic [7:0] mask;         // irq_mask_reg
    logic       expired_n;    // watchdog_expired_flag (1 = no timeout)
  } tmrwd_stat_t;

endpackage : tmrwd_pkg

// File: hdl/tmrwd_top.sv
/*
  tmrwd_top: 8-bit timer/counter, watchdog, shared prescaler and the
  interrupt flag / vectoring logic of a small microcontroller core.
  assumes: the core decodes instructions and pulses cmd strobes for one
  clock inside the instruction cycle; pins are asynchronous to ref_clk.
*/
// Summary of operation
// - config-load copies work register into 7-bit config
// - reset sets all config bits but irq edge
// - rate field selects ratio, doubling each step
// - owner bit one gives prescaler to watchdog
// - edge bit one counts falling external edges
// - source bit one selects external clock pin
// - irq edge bit one means rising edge
// - timer mode undivided counts each instruction cycle
// - count write inhibits increments for two cycles
// - counter input sampled twice before increment
// - watchdog timeout resets device, clears expired flag
// - watchdog disabled while enable bit is zero
// - timeout 18 ms, extended by prescaler ratio
// - kick clears watchdog and its prescaler
// - sleep clears watchdog and its prescaler
// - one down-counting prescaler, one owner only
// - count write clears timer-owned prescaler
// - prescaler hidden, all ones on reset
// - flags set regardless of individual enables
// - taken hardware irq clears master enable, vectors 008h
// - flag read returns flags and mask
// - count wrap sets overflow flag
// - selected edge on pin a sets flag
// - falling edge on pin b sets flag
module tmrwd_top
  import tmrwd_pkg::*;
#(
  parameter int WDT_CYC = WDT_TIMEOUT_CYC           // shorten in simulation
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire tmrwd_cmd_t  cmd,
  input  wire logic        ext_count_clock_pin,
  input  wire logic        ext_irq_a_pin,
  input  wire logic        ext_irq_b_pin,
  input  wire logic        watchdog_osc_tick,
  output tmrwd_stat_t      stat,
  output logic             irq_fetch,
  output logic [11:0]      irq_vector,
  output logic             watchdog_reset,
  output logic [6:0]       timer_config
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [6:0]  cfg;           // timer_config
    logic [7:0]  count;         // count_register
    logic [7:0]  presc;         // shared prescaler, down counter
    logic [1:0]  holdoff;       // increments still inhibited
    logic [1:0]  div;           // instruction cycle divider
    logic [31:0] wdt;           // watchdog counter
    logic        wdt_en;        // watchdog_enable_bit
    logic        exp_n;         // watchdog_expired_flag
    logic [7:0]  flags;         // irq_flag_reg
    logic [7:0]  mask;          // irq_mask_reg
    logic [2:0]  cclk_s;        // count pin synchroniser
    logic [2:0]  ia_s;          // pin a synchroniser
    logic [2:0]  ib_s;          // pin b synchroniser
    logic [2:0]  wo_s;          // watchdog oscillator synchroniser
    logic        cclk_q;        // accepted count pin level
    logic        ia_q;          // accepted pin a level
    logic        ib_q;          // accepted pin b level
    logic        wo_q;          // accepted oscillator level
    logic        pout_q;        // prescaler output, sampled late phase
    logic        pout_e;        // prescaler output, sampled early phase
    logic        fetch;         // vector fetch pulse
    logic [11:0] vec;           // vector address
    logic        wrst;          // watchdog reset pulse
    logic [7:0]  flag_rd;       // flags and mask, registered read value
  } tmrwd_state_t;

  tmrwd_state_t st_ff;          // registered state
  tmrwd_state_t nxt_st;         // next state

  // ************************************************************
  // combinational next state
  // ************************************************************
  logic        instr_tick;      // one clock per instruction cycle
  logic        ext_edge;        // selected external count edge
  logic        presc_tick;      // prescaler output event
  logic        cnt_tick;        // increment request for count
  logic        wdt_tick;        // watchdog oscillator rising edge
  logic        wdt_stage;       // watchdog timebase expiry
  logic        to_wdt;          // prescaler owned by the watchdog
  logic [7:0]  ratio_mask;      // prescaler tap mask
  logic [7:0]  pending;         // enabled and flagged sources

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.fetch = 1'b0;
    nxt_st.wrst  = 1'b0;
    to_wdt     = st_ff.cfg[CFG_OWNER_BIT];
    instr_tick = (st_ff.div == 2'h3);
    nxt_st.div = st_ff.div + 2'h1;

    // pin synchronisers; only the agreeing later stages are used
    nxt_st.cclk_s = {st_ff.cclk_s[1:0], ext_count_clock_pin};
    nxt_st.ia_s   = {st_ff.ia_s[1:0], ext_irq_a_pin};
    nxt_st.ib_s   = {st_ff.ib_s[1:0], ext_irq_b_pin};
    nxt_st.wo_s   = {st_ff.wo_s[1:0], watchdog_osc_tick};
    if (st_ff.cclk_s[2] == st_ff.cclk_s[1]) nxt_st.cclk_q = st_ff.cclk_s[2];
    if (st_ff.ia_s[2] == st_ff.ia_s[1])     nxt_st.ia_q   = st_ff.ia_s[2];
    if (st_ff.ib_s[2] == st_ff.ib_s[1])     nxt_st.ib_q   = st_ff.ib_s[2];
    if (st_ff.wo_s[2] == st_ff.wo_s[1])     nxt_st.wo_q   = st_ff.wo_s[2];

    // edge on count pin; edge bit one picks falling
    ext_edge = st_ff.cfg[CFG_EDGE_BIT] ? (st_ff.cclk_q & ~nxt_st.cclk_q)
                                       : (~st_ff.cclk_q & nxt_st.cclk_q);
    wdt_tick = ~st_ff.wo_q & nxt_st.wo_q;

    // ratio: timer gets 2<<n, watchdog 1<<n; mask picks the tap bits
    ratio_mask = 8'hff >> (3'h7 - st_ff.cfg[CFG_RATE_LSB +: 3]);
    // watchdog base period runs on oscillator edges, so it keeps time in sleep
    wdt_stage  = st_ff.wdt_en && wdt_tick && (st_ff.wdt >= 32'(WDT_CYC - 1));
    presc_tick = 1'b0;
    // the prescaler clocks from whichever unit owns it; as a postscaler it
    // counts whole base periods of the watchdog, never raw oscillator edges
    if (to_wdt ? wdt_stage : (st_ff.cfg[CFG_SRC_BIT] ? ext_edge : instr_tick)) begin
      nxt_st.presc = st_ff.presc - 8'h1;
      // down counter from all ones: the low tap bits read zero once per ratio
      presc_tick   = to_wdt ? ((st_ff.presc & {1'b0, ratio_mask[7:1]}) == 8'h0)
                            : ((st_ff.presc & ratio_mask) == 8'h0);
    end

    // timer input: counter mode passes through the two-phase sampler
    nxt_st.pout_e = to_wdt ? ext_edge : (st_ff.cfg[CFG_SRC_BIT] ? presc_tick : 1'b0);
    nxt_st.pout_q = st_ff.pout_e;
    if (st_ff.cfg[CFG_SRC_BIT]) begin
      cnt_tick = st_ff.pout_q;
    end else begin
      cnt_tick = to_wdt ? instr_tick : presc_tick;
    end

    // count register; wrap keeps running and sets sticky flag
    if (instr_tick && st_ff.holdoff != 2'h0) begin
      nxt_st.holdoff = st_ff.holdoff - 2'h1;
    end
    if (cmd.cnt_write) begin
      nxt_st.count   = cmd.wdata;
      nxt_st.holdoff = 2'(WRITE_HOLDOFF);
      if (!to_wdt) nxt_st.presc = PRESC_RESET;
    end else if (cnt_tick && st_ff.holdoff == 2'h0) begin
      nxt_st.count = st_ff.count + 8'h1;
    end

    // configuration load from the work register
    if (cmd.cfg_load) nxt_st.cfg = cmd.wdata[CFG_W-1:0];
    if (cmd.pwr_write) nxt_st.wdt_en = cmd.wdata[PWR_WDT_EN_BIT];

    // watchdog: base period, then postscaled by the prescaler if owned;
    // kick and sleep clear the prescaler when the watchdog owns it, even while the watchdog is off
    if (cmd.kick || cmd.sleep) begin
      nxt_st.wdt = 32'h0;
      if (to_wdt) nxt_st.presc = PRESC_RESET;
    end else if (!st_ff.wdt_en) begin
      nxt_st.wdt = 32'h0;
    end else if (wdt_stage) begin
      nxt_st.wdt = 32'h0;
      // without the prescaler every base period is a timeout
      if (!to_wdt || presc_tick) begin
        nxt_st.wrst  = 1'b1;
        nxt_st.exp_n = 1'b0;
        // restart the postscaler so the next timeout is a full ratio away
        if (to_wdt) nxt_st.presc = PRESC_RESET;
      end
    end else if (wdt_tick) begin
      nxt_st.wdt = st_ff.wdt + 32'h1;
    end
    if (cmd.sleep || cmd.kick) nxt_st.exp_n = 1'b1;

    // flag register: software write first, hardware sets win
    if (cmd.flag_write) nxt_st.flags = cmd.wdata & IRQ_FLAG_IMPL;
    if (cmd.mask_write) nxt_st.mask  = cmd.wdata & IRQ_MASK_IMPL;
    if (cnt_tick && st_ff.holdoff == 2'h0 && !cmd.cnt_write && st_ff.count == 8'hff)
      nxt_st.flags[IRQ_OVF_BIT] = 1'b1;
    if (st_ff.cfg[CFG_IRQA_BIT] ? (~st_ff.ia_q & nxt_st.ia_q) : (st_ff.ia_q & ~nxt_st.ia_q))
      nxt_st.flags[IRQ_A_BIT] = 1'b1;
    if (st_ff.ib_q & ~nxt_st.ib_q)
      nxt_st.flags[IRQ_B_BIT] = 1'b1;

    // vectoring: hardware sources under master enable
    pending = st_ff.flags & st_ff.mask & IRQ_FLAG_IMPL;
    if (cmd.ret) nxt_st.mask[IRQ_MASTER_BIT] = 1'b1;
    if (cmd.sw_irq) begin
      nxt_st.fetch = 1'b1;
      nxt_st.vec   = SW_VECTOR;
    end else if (st_ff.mask[IRQ_MASTER_BIT] && pending != 8'h0) begin
      nxt_st.fetch = 1'b1;
      nxt_st.vec   = HW_VECTOR;
      nxt_st.mask[IRQ_MASTER_BIT] = 1'b0;
    end

    // read value registered from the next flags and mask, so it tracks them
    // in the same cycle and the port still comes straight from a flip-flop
    nxt_st.flag_rd = nxt_st.flags & nxt_st.mask;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff       <= '0;
      st_ff.cfg   <= CFG_RESET;
      st_ff.presc <= PRESC_RESET;
      st_ff.exp_n <= 1'b1;
      st_ff.wdt_en <= 1'b1;
      st_ff.ia_q  <= 1'b1;
      st_ff.ib_q  <= 1'b1;
      // pins a and b idle high: start their synchronisers high as well, or
      // the first cycles would show a false falling edge and set a flag
      st_ff.ia_s  <= 3'h7;
      st_ff.ib_s  <= 3'h7;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flip-flops
  assign stat.count     = st_ff.count;
  assign stat.flag_read = st_ff.flag_rd;
  assign stat.mask      = st_ff.mask;
  assign stat.expired_n = st_ff.exp_n;
  assign irq_fetch      = st_ff.fetch;
  assign irq_vector     = st_ff.vec;
  assign watchdog_reset = st_ff.wrst;
  assign timer_config   = st_ff.cfg;

  // ************************************************************
  // checks
  // ************************************************************
  property p_cfg_load;
    @(posedge ref_clk) disable iff (rst) cmd.cfg_load |=> timer_config == $past(cmd.wdata[6:0]);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config not loaded");

  property p_cfg_reset;
    @(posedge ref_clk) $past(rst) && !rst |-> timer_config == 7'h3f;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config reset wrong");

  property p_holdoff;
    @(posedge ref_clk) disable iff (rst) cmd.cnt_write ##1 !cmd.cnt_write [*4] |-> stat.count == $past(stat.count, 3);
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("count moved during holdoff");

  property p_wdt_off;
    @(posedge ref_clk) disable iff (rst) !st_ff.wdt_en |=> !watchdog_reset;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("watchdog fired while disabled");

  property p_wdt_flag;
    @(posedge ref_clk) disable iff (rst) watchdog_reset |-> !stat.expired_n;
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("expired flag not cleared");

  property p_flag_and;
    @(posedge ref_clk) disable iff (rst) stat.flag_read == (st_ff.flags & stat.mask);
  endproperty
  a_flag_and: assert property (p_flag_and) else $error("flag read not masked");

  property p_hw_vec;
    @(posedge ref_clk) disable iff (rst) irq_fetch && irq_vector == 12'h008 |-> !stat.mask[7];
  endproperty
  a_hw_vec: assert property (p_hw_vec) else $error("master enable left set");

  property p_sw_vec;
    @(posedge ref_clk) disable iff (rst) cmd.sw_irq |=> irq_fetch && irq_vector == 12'h002;
  endproperty
  a_sw_vec: assert property (p_sw_vec) else $error("software vector wrong");

  property p_wrap;
    @(posedge ref_clk) disable iff (rst) $past(stat.count) == 8'hff && stat.count == 8'h00 && !$past(cmd.cnt_write)
      |-> st_ff.flags[0];
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow flag not set");

  property p_presc_kick;
    @(posedge ref_clk) disable iff (rst) (cmd.kick || cmd.sleep) && st_ff.cfg[CFG_OWNER_BIT]
      |=> st_ff.presc == PRESC_RESET;
  endproperty
  a_presc_kick: assert property (p_presc_kick) else $error("watchdog prescaler not cleared");

  property p_presc_cnt;
    @(posedge ref_clk) disable iff (rst) cmd.cnt_write && !st_ff.cfg[CFG_OWNER_BIT] |=> st_ff.presc == PRESC_RESET;
  endproperty
  a_presc_cnt: assert property (p_presc_cnt) else $error("timer prescaler not cleared");

  property p_exp_kick;
    @(posedge ref_clk) disable iff (rst) cmd.kick |=> stat.expired_n && !watchdog_reset;
  endproperty
  a_exp_kick: assert property (p_exp_kick) else $error("kick did not stop the watchdog");

  c_wrap:   cover property (@(posedge ref_clk) disable iff (rst) $rose(st_ff.flags[0]));
  c_hw_irq: cover property (@(posedge ref_clk) disable iff (rst) irq_fetch && irq_vector == 12'h008);
  c_wdt:    cover property (@(posedge ref_clk) disable iff (rst) watchdog_reset);
  c_sw_irq: cover property (@(posedge ref_clk) disable iff (rst) irq_fetch && irq_vector == 12'h002);

endmodule : tmrwd_top

// File: test/testbench.sv
/*
  testbench: drives instruction strobes into tmrwd_top and checks the
  config, timer, prescaler, interrupt and watchdog behaviour at its ports.
  assumes: tmrwd_pins_model plays the pins; watchdog base period shortened
  to 8 oscillator periods.
*/
module testbench
  import tmrwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // strobes, signals and counters
  // ************************************************************
  localparam int         WDT_SIM = 8;        // short watchdog keeps the run brief
  localparam logic [8:0] S_CFG   = 9'h100;
  localparam logic [8:0] S_CNT   = 9'h080;
  localparam logic [8:0] S_KICK  = 9'h040;
  localparam logic [8:0] S_SLEEP = 9'h020;
  localparam logic [8:0] S_RET   = 9'h010;
  localparam logic [8:0] S_SW    = 9'h008;
  localparam logic [8:0] S_MASK  = 9'h004;
  localparam logic [8:0] S_FLAG  = 9'h002;
  localparam logic [8:0] S_PWR   = 9'h001;

  logic        ref_clk;
  logic        rst;
  tmrwd_cmd_t  cmd;
  logic        cnt_pin;
  logic        irq_a;
  logic        irq_b;
  logic        osc;
  tmrwd_stat_t stat;
  logic        irq_fetch;
  logic [11:0] irq_vector;
  logic        watchdog_reset;
  logic [6:0]  timer_config;
  int          failures;
  int          total_checks;
  int          wd_count = 0;                 // watchdog reset pulses seen
  logic [7:0]  c0;                           // count at last observed step
  bit          seen;

  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  tmrwd_top #(.WDT_CYC(WDT_SIM)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .cmd(cmd), .ext_count_clock_pin(cnt_pin),
    .ext_irq_a_pin(irq_a), .ext_irq_b_pin(irq_b), .watchdog_osc_tick(osc),
    .stat(stat), .irq_fetch(irq_fetch), .irq_vector(irq_vector),
    .watchdog_reset(watchdog_reset), .timer_config(timer_config));

  tmrwd_pins_model pins_u (
    .ext_count_clock_pin(cnt_pin), .ext_irq_a_pin(irq_a),
    .ext_irq_b_pin(irq_b), .watchdog_osc_tick(osc));

  // count watchdog resets as they pulse for one cycle
  always @(posedge ref_clk) begin
    if (watchdog_reset === 1'b1) begin
      wd_count++;
    end
  end

  // ************************************************************
  // tasks
  // ************************************************************
  // step n edges, then let their updates land before sampling
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // one instruction: strobe held for exactly one edge
  task automatic op(input logic [8:0] s, input logic [7:0] d);
    @(posedge ref_clk);
    cmd <= tmrwd_cmd_t'({s, d});
    @(posedge ref_clk);
    cmd <= '0;
    #1;
  endtask : op

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // bounded wait for the fetch pulse, vector checked in its cycle
  task automatic wait_fetch(input logic [11:0] vec);
    seen = 0;
    for (int i = 0; i < 12 && !seen; i++) begin
      if (irq_fetch === 1'b1) seen = 1;
      else tick(1);
    end
    chk(12'(seen), 12'h001);
    chk(irq_vector, vec);
  endtask : wait_fetch

  // bounded wait for the next count step
  task automatic wait_change(input int lim);
    c0 = stat.count;
    for (int i = 0; i < lim && stat.count === c0; i++) tick(1);
    c0 = stat.count;
  endtask : wait_change

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  // watchdog on the run: roughly eight times the expected length
  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    close_out();
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    rst          = 1'b1;
    cmd          = '0;
    failures     = 0;
    total_checks = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk(timer_config, CFG_RESET);
    chk(stat.mask, 8'h00);
    chk(stat.expired_n, 1'b1);
    op(S_PWR, 8'h00);
    op(S_CFG, 8'hff); chk(timer_config, 7'h7f);
    op(S_CFG, 8'h07); chk(timer_config, 7'h07);
    $display("test config finished");
    // undivided timer and write holdoff
    op(S_CFG, 8'h08); op(S_KICK, 8'h00);
    op(S_CNT, 8'h10); tick(4); chk(stat.count, 8'h10);
    wait_change(20); tick(40); chk(stat.count, c0 + 12'd10);
    // every rate code on the timer; count write clears the prescaler
    for (int r = 0; r < 8; r++) begin
      op(S_CFG, 8'(r)); op(S_CNT, 8'h00);
      wait_change(4 * (2 << r) + 40);
      tick(8 * (2 << r)); chk(stat.count, c0 + 12'd2);
    end
    $display("test timer finished");
    // overflow flag, masking, vectoring
    op(S_CFG, 8'h08); op(S_MASK, 8'h01); op(S_FLAG, 8'h00); op(S_CNT, 8'hfc);
    for (int i = 0; i < 60 && stat.count !== 8'h00; i++) tick(1);
    tick(6); chk(stat.flag_read, 8'h01);
    tick(8); chk(12'(stat.count != 8'h00), 12'h001);
    chk(stat.flag_read, 8'h01);
    op(S_MASK, 8'h00); chk(stat.flag_read, 8'h00);
    op(S_MASK, 8'h01); chk(stat.flag_read, 8'h01);
    op(S_MASK, 8'h81); wait_fetch(HW_VECTOR);
    tick(1); chk(stat.mask, 8'h01);
    op(S_FLAG, 8'h00); op(S_RET, 8'h00); chk(stat.mask, 8'h81);
    op(S_SW, 8'h00); wait_fetch(SW_VECTOR);
    $display("test irq finished");
    // pin a on both edge selections, pin b on falling only
    for (int s = 0; s < 2; s++) begin
      op(S_CFG, 8'(s * 64 + 8)); op(S_MASK, 8'h0c);
      pins_u.drive(1, s[0]); op(S_FLAG, 8'h00);
      pins_u.drive(1, !s[0]); chk(stat.flag_read, 8'h00);
      pins_u.drive(1, s[0]); chk(stat.flag_read, 8'h04);
    end
    pins_u.drive(2, 1'b0); op(S_FLAG, 8'h00);
    pins_u.drive(2, 1'b1); chk(stat.flag_read, 8'h00);
    pins_u.drive(2, 1'b0); chk(stat.flag_read, 8'h08);
    $display("test pins finished");
    // counter mode: five rising and four falling edges, pin left high
    for (int e = 0; e < 2; e++) begin
      op(S_CFG, 8'(8'h28 | e * 16)); pins_u.drive(0, 1'b0);
      op(S_CNT, 8'h00); tick(12);
      repeat (4) begin
        pins_u.drive(0, 1'b1);
        pins_u.drive(0, 1'b0);
      end
      pins_u.drive(0, 1'b1); tick(8);
      chk(stat.count, 12'(5 - e));
    end
    $display("test counter finished");
    // watchdog kicked, slept, starved, then disabled
    op(S_CFG, 8'h00); op(S_KICK, 8'h00); op(S_PWR, 8'h80);
    repeat (3) begin
      tick(40);
      op(S_KICK, 8'h00);
    end
    chk(12'(wd_count), 12'h000);
    tick(40); op(S_SLEEP, 8'h00); tick(40);
    chk(12'(wd_count), 12'h000);
    tick(45); chk(12'(wd_count), 12'h001);
    chk(stat.expired_n, 1'b0);
    op(S_KICK, 8'h00); chk(stat.expired_n, 1'b1);
    op(S_PWR, 8'h00); tick(200); chk(12'(wd_count), 12'h001);
    // watchdog owns the prescaler at 1:2: only every second base period resets
    op(S_CFG, 8'h09); op(S_KICK, 8'h00); op(S_PWR, 8'h80);
    tick(100); chk(12'(wd_count), 12'h001);
    tick(80); chk(12'(wd_count), 12'h002);
    op(S_PWR, 8'h00);
    $display("test watchdog finished");
    close_out();
  end
endmodule : testbench

// File: test/tmrwd_pins_model.sv
/*
  tmrwd_pins_model: far-side stand-in for the count clock pin, the two
  interrupt pins and the free-running watchdog rc oscillator.
  assumes: the bench calls drive() by hierarchical name; pins are async.
*/
module tmrwd_pins_model (
  output logic ext_count_clock_pin,  // external count clock
  output logic ext_irq_a_pin,        // interrupt pin a
  output logic ext_irq_b_pin,        // interrupt pin b
  output logic watchdog_osc_tick     // rc oscillator output
);
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // idle levels and oscillator
  // ************************************************************
  initial begin
    ext_count_clock_pin = 1'b0;
    ext_irq_a_pin       = 1'b1;
    ext_irq_b_pin       = 1'b1;
    watchdog_osc_tick   = 1'b0;
  end

  // oscillator runs free, unrelated in phase to ref_clk
  always #23 watchdog_osc_tick = ~watchdog_osc_tick;

  // ************************************************************
  // pin driver
  // ************************************************************
  // each level is held 8 ref_clk periods, well over the two-phase minimum
  task automatic drive(input int pin, input logic v);
    #7;
    case (pin)
      0:       ext_count_clock_pin = v;
      1:       ext_irq_a_pin       = v;
      default: ext_irq_b_pin       = v;
    endcase
    #40;
  endtask : drive
endmodule : tmrwd_pins_model
